// *** verif/mht_far_end.sv ***
// Purpose: far side model giving ring bursts and line voltage
// Assumes: driven from the bench process
// Notes: gap sets prompt or slow pulse spacing
`timescale 1ns/1ps
`default_nettype none
module mht_far_end (
  input wire logic ref_clk,
  output logic ring_pulse,
  output logic ring_burst,
  output logic [7:0] line_meas
);
  initial begin
    ring_pulse = 1'b0;
    ring_burst = 1'b0;
    line_meas = 8'h00;
  end
  task automatic ring(input int n, input int gap);
    ring_burst <= 1'b1;
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge ref_clk);
      ring_pulse <= 1'b1;
      repeat (gap) @(posedge ref_clk);
      ring_pulse <= 1'b0;
    end
    repeat (gap + 2) @(posedge ref_clk);
    ring_burst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic volts(input logic [7:0] v);
    line_meas <= v;
  endtask
endmodule // mht_far_end
`default_nettype wire

// *** verif/mht_timing_regs_sva.sv ***
// Purpose: checker for the handshake timing register bank ports
// Assumes: shortened tick periods in simulation
// Notes: bound onto every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module mht_timing_regs_chk
  import mht_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire mht_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire mht_seq_in_t seq_in,
  input wire mht_seq_out_t seq_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // readings within two volts of zero report as zero
  function automatic logic [7:0] vfix(input logic [7:0] m);
    return ($signed(m) > -8'sd3 && $signed(m) < 8'sd3) ? 8'h00 : m;
  endfunction
  sequence s_volt_rd;
    bus_req.rd && bus_req.addr == 8'hdb && $stable(seq_in.line_meas);
  endsequence
  sequence s_ans_start;
    $rose(seq_in.run[CH_ANS_DET]);
  endsequence
  property p_volt;
    s_volt_rd |=> bus_rdata == vfix($past(seq_in.line_meas));
  endproperty
  property p_rd_idle;
    !bus_req.rd |=> bus_rdata == 8'h00;
  endproperty
  property p_ans_early;
    s_ans_start |=> !seq_out.done[CH_ANS_DET];
  endproperty
  property p_fsk_clr;
    !seq_in.run[CH_FSK] |=> !seq_out.done[CH_FSK];
  endproperty
  property p_abort;
    seq_out.call_abort |-> seq_out.done[CH_CD_WAIT] && !$past(seq_out.done[CH_CD_WAIT]);
  endproperty
  property p_kiss;
    seq_out.kissoff_echo |-> $rose(seq_out.done[CH_KISS]);
  endproperty
  property p_ovc;
    seq_out.overcurrent |-> seq_out.done[CH_OVC];
  endproperty
  property p_intr;
    seq_out.intrusion_blocked |-> $past(seq_in.run[CH_INTR]);
  endproperty
  property p_ring;
    seq_out.ring_qualified |-> $past(seq_in.ring_burst);
  endproperty
  a_volt: assert property (p_volt) else $error("line voltage read wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_ans_early: assert property (p_ans_early) else $error("answer tone early");
  a_fsk_clr: assert property (p_fsk_clr) else $error("fsk done not cleared");
  a_abort: assert property (p_abort) else $error("abort without timeout");
  a_kiss: assert property (p_kiss) else $error("echo without kissoff");
  a_ovc: assert property (p_ovc) else $error("overcurrent before delay");
  a_intr: assert property (p_intr) else $error("blocked while idle");
  a_ring: assert property (p_ring) else $error("ring outside burst");
endmodule // mht_timing_regs_chk
bind mht_timing_regs mht_timing_regs_chk u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .seq_in(seq_in), .seq_out(seq_out));
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the timing register bank
// Assumes: tick periods shortened to 5,30,32,300,600 cycles
// Notes: read data checked against a queue of expected values
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mht_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  mht_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata, v;
  logic [NCH-1:0] run = '0;
  logic sec_mode = 1'b0;
  logic [1:0] sense = 2'b00;
  logic ring_pulse, ring_burst, rd_d = 1'b0;
  logic [7:0] line_meas, exp_q[$];
  logic [7:0] vt[6] = '{8'h0c, 8'hf4, 8'h02, 8'hfe, 8'h03, 8'hfd};
  logic [15:0] tv[17] = '{16'h2a04, 16'h2b03, 16'h2c02, 16'h2d04, 16'h2e02, 16'h2f02,
    16'h3001, 16'h3104, 16'h3203, 16'h1e00, 16'h3404, 16'h3503, 16'h3603, 16'h3702,
    16'h3902, 16'h3a03, 16'h2902};
  int error_cnt = 0, num_checks = 0, seed = 72607;
  int kiss_n = 0, abort_n = 0, ovc_n = 0, intr_n = 0, ring_n = 0;
  mht_seq_in_t seq_in;
  mht_seq_out_t seq_out;
  always #2.5 ref_clk = ~ref_clk;
  assign seq_in = {run, sec_mode, ring_pulse, ring_burst, sense, line_meas};
  mht_timing_regs #(.FINE_TICK_CYC(5), .TEN_TICK_CYC(30), .DLY_TICK_CYC(32),
    .HALF_TICK_CYC(300), .SEC_TICK_CYC(600)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .seq_in(seq_in), .seq_out(seq_out));
  mht_far_end u_far (.ref_clk(ref_clk), .ring_pulse(ring_pulse),
    .ring_burst(ring_burst), .line_meas(line_meas));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one bus cycle; a read notes its expected data d
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w) exp_q.push_back(d);
    @(posedge ref_clk);
    bus_req <= '{a, d, w, !w};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask
  // done must follow run within the tick window of the programmed limit
  task automatic tm(input int ch, input int lim, input int per);
    int n = 0;
    @(posedge ref_clk);
    run[ch] <= 1'b1;
    while (seq_out.done[ch] !== 1'b1 && n < lim * per + 20) begin
      @(posedge ref_clk);
      n++;
    end
    check(n >= (lim - 1) * per + 2 && n <= lim * per + 5, 1'b1);
    run[ch] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(seq_out.done[ch], 1'b0);
  endtask
  always @(posedge ref_clk) begin
    rd_d <= bus_req.rd;
    if (rd_d) check(bus_rdata, exp_q.pop_front());
    kiss_n += (seq_out.kissoff_echo === 1'b1);
    abort_n += (seq_out.call_abort === 1'b1);
    ovc_n += (seq_out.overcurrent === 1'b1);
    intr_n += (seq_out.intrusion_blocked === 1'b1);
    ring_n += (seq_out.ring_qualified === 1'b1);
  end
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < NREG; i++) bus(1'b0, REG_OFS[i], REG_RST[i]);
    bus(1'b1, 8'hdb, 8'h55);
    bus(1'b0, 8'h33, 8'h00);
    for (int i = 0; i < NREG; i++) begin
      v = 8'($random(seed));
      bus(1'b1, REG_OFS[i], v);
      bus(1'b0, REG_OFS[i], v);
    end
    foreach (vt[i]) begin
      u_far.volts(vt[i]);
      repeat (3) @(posedge ref_clk);
      bus(1'b0, 8'hdb, ($signed(vt[i]) > -3 && $signed(vt[i]) < 3) ? 8'h00 : vt[i]);
    end
    sec_mode <= 1'b1;
    sense <= 2'b01;
    bus(1'b1, 8'h82, 8'h04);
    bus(1'b1, 8'h28, 8'h01);
    bus(1'b1, 8'h27, 8'h03);
    foreach (tv[i]) bus(1'b1, tv[i][15:8], tv[i][7:0]);
    tm(CH_BIS_ONES, 4, 5);
    tm(CH_DT_CARR, 3, 5);
    tm(CH_DT_SRCH, 258, 5);
    tm(CH_SL_LOSS, 4, 5);
    tm(CH_RV_SRCH, 2, 5);
    tm(CH_FSK, 258, 5);
    tm(CH_ANS_DET, 4, 5);
    tm(CH_OVC, 3, 5);
    tm(CH_ANS_LEN, 4, 5);
    tm(CH_V22_ONES, 3, 5);
    tm(CH_KISS, 4, 30);
    tm(CH_CD_RET, 2, 5);
    tm(CH_CD_WAIT, 2, 600);
    tm(CH_ANS_DLY, 3, 32);
    tm(CH_INTR, 2, 300);
    tm(CH_TX2400, 259, 5);
    bus(1'b1, 8'h1e, 8'h02);
    tm(CH_ANS_LEN, 2, 600);
    check(kiss_n, 1);
    check(abort_n, 1);
    check(ovc_n > 0, 1'b1);
    check(intr_n > 0, 1'b1);
    bus(1'b1, 8'h3b, 8'h03);
    u_far.ring(2, 4);
    check(ring_n, 0);
    u_far.ring(3, 1);
    check(ring_n > 0, 1'b1);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire

// *** verilog/mht_pkg.sv ***
// Purpose: constants and types for the handshake timing register bank
// Assumes: 200 MHz reference clock
// Notes: register slots are held as one array indexed by the IX_ constants
package mht_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and tick periods (times in microseconds, some as fractions)
  localparam int CLK_MHZ = 200;
  localparam int FINE_US_NUM = 5000;
  localparam int FINE_US_DEN = 3;
  localparam int TEN_US = 10000;
  localparam int DLY_US_NUM = 160000;
  localparam int DLY_US_DEN = 3;
  localparam int HALF_US = 500000;
  localparam int SEC_US = 1000000;
  localparam int FINE_CYC = FINE_US_NUM * CLK_MHZ / FINE_US_DEN;
  localparam int TEN_CYC = TEN_US * CLK_MHZ;
  localparam int DLY_CYC = DLY_US_NUM * CLK_MHZ / DLY_US_DEN;
  localparam int HALF_CYC = HALF_US * CLK_MHZ;
  localparam int SEC_CYC = SEC_US * CLK_MHZ;
  localparam int TICK_W = 28;
  localparam int NUNIT = 5;
  localparam int U_FINE = 0, U_TEN = 1, U_DLY = 2, U_HALF = 3, U_SEC = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register slots
  localparam int NREG = 26;
  localparam int IX_ANS_SECS = 0, IX_TX_LO = 1, IX_TX_HI = 2, IX_SUSP = 3;
  localparam int IX_BIS_ONES = 4, IX_DT_CARR = 5, IX_DT_SRCH = 6, IX_SL_LOSS = 7;
  localparam int IX_RV_SRCH = 8, IX_FSK_LO = 9, IX_FSK_HI = 10, IX_ANS_DET = 11;
  localparam int IX_OVC = 12, IX_ANS_FINE = 13, IX_V22_ONES = 14, IX_KISS = 15;
  localparam int IX_CD_RET = 16, IX_CD_WAIT = 17, IX_ANS_DLY = 18, IX_RING_MIN = 19;
  localparam int IX_CID = 20, IX_RING = 21, IX_INTR = 22, IX_DIAG = 23;
  localparam int IX_CFG1 = 24, IX_GPIO_ONE = 25;
  localparam logic [7:0] REG_OFS [NREG] = '{
    8'h1e, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e,
    8'h2f, 8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39,
    8'h3a, 8'h3b, 8'h3c, 8'h62, 8'h82, 8'hdf, 8'he0, 8'he1};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h03, 8'h78, 8'h08, 8'h00, 8'hd2, 8'h18, 8'h08, 8'h0c, 8'hf0,
    8'h3c, 8'h00, 8'h3c, 8'h0c, 8'h5a, 8'ha2, 8'h30, 8'h20, 8'h3c,
    8'h29, 8'h03, 8'h01, 8'h41, 8'h08, 8'h0c, 8'h22, 8'h04};
  localparam logic [7:0] OFS_LINE_VOLT = 8'hdb;
  localparam int IB_LSB = 1;
  localparam logic [1:0] IB_SUSPEND = 2'h2;
  localparam logic [15:0] SEARCH_BASE = 16'h0100;
  localparam logic signed [7:0] VOLT_FLOOR = 8'sh03;

  ////////////////////////////////////////////////////////////////////////////
  // timer channels
  localparam int NCH = 16;
  localparam int CH_TX2400 = 0, CH_BIS_ONES = 1, CH_DT_CARR = 2;
  localparam int CH_DT_SRCH = 3, CH_SL_LOSS = 4, CH_RV_SRCH = 5;
  localparam int CH_FSK = 6, CH_ANS_DET = 7, CH_OVC = 8, CH_ANS_LEN = 9;
  localparam int CH_V22_ONES = 10, CH_KISS = 11, CH_CD_RET = 12;
  localparam int CH_CD_WAIT = 13, CH_ANS_DLY = 14, CH_INTR = 15;

  typedef logic [NREG-1:0][7:0] mht_regs_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mht_bus_req_t;

  typedef struct packed {
    logic [NCH-1:0] run;
    logic security_mode;
    logic ring_pulse;
    logic ring_burst;
    logic [1:0] loop_sense;
    logic [7:0] line_meas;
  } mht_seq_in_t;

  typedef struct packed {
    logic [NCH-1:0] done;
    logic intrusion_blocked;
    logic overcurrent;
    logic ring_qualified;
    logic kissoff_echo;
    logic call_abort;
  } mht_seq_out_t;

endpackage

// *** verilog/mht_timing_regs.sv ***
// Purpose: handshake and call-progress timing registers with qualifier timers
// Assumes: sequencer inputs synchronous to ref_clk
// Notes: all timers share one set of free-running tick generators
// Behaviour
// [RULE1] 2400 tx length is high*256 plus low steps
// [RULE2] suspend intrusion after dialing when mode suspends
// [RULE3] bis answerer needs scrambled ones minimum time
// [RULE4] master carrier must persist before turnaround
// [RULE5] turnaround search lasts 426.66 ms plus count
// [RULE6] slave needs carrier absent before reverse search
// [RULE7] slave reverse search limited to programmed count
// [RULE8] fsk connect waits low plus high*256 steps
// [RULE9] answer tone reported after minimum presence
// [RULE10] sample loop current after overcurrent delay
// [RULE11] fine answer length used only if seconds zero
// [RULE12] v22 originator needs scrambled ones minimum time
// [RULE13] echo k when kissoff exceeds count
// [RULE14] carrier restored after minimum return time
// [RULE15] abort call without carrier within seconds count
// [RULE16] delay answer tone after off-hook
// [RULE17] ring burst needs minimum consecutive pulses
// [RULE18] line voltage signed volts, zero under 3 V
// [RULE19] 2400 tx low part in fine steps
// [RULE20] answer tone length in whole seconds
// [RULE21] shared tick generators drive all timing
// [RULE22] registers reset to defaults, voltage live
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module mht_timing_regs
  import mht_pkg::*;
#(
  parameter int FINE_TICK_CYC = FINE_CYC,
  parameter int TEN_TICK_CYC = TEN_CYC,
  parameter int DLY_TICK_CYC = DLY_CYC,
  parameter int HALF_TICK_CYC = HALF_CYC,
  parameter int SEC_TICK_CYC = SEC_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire mht_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire mht_seq_in_t seq_in,
  output mht_seq_out_t seq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks

  localparam int TICK_MAX = (1 << TICK_W) - 1;

  if (FINE_TICK_CYC < 1 || FINE_TICK_CYC > TICK_MAX) begin : g_chk_fine
    $error("fine tick period out of range");
  end
  if (TEN_TICK_CYC < 1 || TEN_TICK_CYC > TICK_MAX) begin : g_chk_ten
    $error("ten ms tick period out of range");
  end
  if (DLY_TICK_CYC < 1 || DLY_TICK_CYC > TICK_MAX) begin : g_chk_dly
    $error("answer delay tick period out of range");
  end
  if (HALF_TICK_CYC < 1 || HALF_TICK_CYC > TICK_MAX) begin : g_chk_half
    $error("half second tick period out of range");
  end
  if (SEC_TICK_CYC < 1 || SEC_TICK_CYC > TICK_MAX) begin : g_chk_sec
    $error("second tick period out of range");
  end
  // channel units assume the tick periods grow with the unit
  if (FINE_TICK_CYC > TEN_TICK_CYC) begin : g_chk_order_fine
    $error("fine tick longer than ten ms tick");
  end
  if (HALF_TICK_CYC > SEC_TICK_CYC) begin : g_chk_order_half
    $error("half second tick longer than second tick");
  end

  localparam logic [TICK_W-1:0] TICK_LAST [NUNIT] = '{
    TICK_W'(FINE_TICK_CYC - 1),
    TICK_W'(TEN_TICK_CYC - 1),
    TICK_W'(DLY_TICK_CYC - 1),
    TICK_W'(HALF_TICK_CYC - 1),
    TICK_W'(SEC_TICK_CYC - 1)};

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    mht_regs_t regs;
    logic [7:0] rdata;
    logic [7:0] line_volt;
    logic [NUNIT-1:0][TICK_W-1:0] tick_cnt;
    logic [NUNIT-1:0] tick;
    logic [NCH-1:0][15:0] cnt;
    logic [NCH-1:0] done;
    logic ring_prev;
    logic [7:0] ring_cnt;
    mht_seq_out_t out;
  } mht_state_t;

  mht_state_t state_ff;
  mht_state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // tick unit of each channel; answer tone length switches unit
  function automatic int chan_unit(input int ch, input logic secs_zero);
    case (ch)
      CH_KISS: begin
        chan_unit = U_TEN;
      end
      CH_CD_WAIT: begin
        chan_unit = U_SEC;
      end
      CH_ANS_DLY: begin
        chan_unit = U_DLY;
      end
      CH_INTR: begin
        chan_unit = U_HALF;
      end
      CH_ANS_LEN: begin
        if (secs_zero) begin
          chan_unit = U_FINE; // [RULE11]
        end else begin
          chan_unit = U_SEC; // [RULE20]
        end
      end
      default: begin
        chan_unit = U_FINE;
      end
    endcase
  endfunction

  // number of ticks a channel must run before it is done
  function automatic logic [15:0] chan_limit(input int ch, input mht_regs_t r);
    case (ch)
      CH_TX2400: begin
        chan_limit = {r[IX_TX_HI], r[IX_TX_LO]}; // [RULE1] [RULE19]
      end
      CH_BIS_ONES: begin
        chan_limit = {8'h00, r[IX_BIS_ONES]}; // [RULE3]
      end
      CH_DT_CARR: begin
        chan_limit = {8'h00, r[IX_DT_CARR]}; // [RULE4]
      end
      CH_DT_SRCH: begin
        chan_limit = SEARCH_BASE + {8'h00, r[IX_DT_SRCH]}; // [RULE5]
      end
      CH_SL_LOSS: begin
        chan_limit = {8'h00, r[IX_SL_LOSS]}; // [RULE6]
      end
      CH_RV_SRCH: begin
        chan_limit = {8'h00, r[IX_RV_SRCH]}; // [RULE7]
      end
      CH_FSK: begin
        chan_limit = {r[IX_FSK_HI], r[IX_FSK_LO]}; // [RULE8]
      end
      CH_ANS_DET: begin
        chan_limit = {8'h00, r[IX_ANS_DET]}; // [RULE9]
      end
      CH_OVC: begin
        chan_limit = {8'h00, r[IX_OVC]}; // [RULE10]
      end
      CH_ANS_LEN: begin
        if (r[IX_ANS_SECS] == 8'h00) begin
          chan_limit = {8'h00, r[IX_ANS_FINE]}; // [RULE11]
        end else begin
          chan_limit = {8'h00, r[IX_ANS_SECS]}; // [RULE20]
        end
      end
      CH_V22_ONES: begin
        chan_limit = {8'h00, r[IX_V22_ONES]}; // [RULE12]
      end
      // strictly longer than the programmed length
      CH_KISS: begin
        chan_limit = {8'h00, r[IX_KISS]} + 16'h0001; // [RULE13]
      end
      CH_CD_RET: begin
        chan_limit = {8'h00, r[IX_CD_RET]}; // [RULE14]
      end
      CH_CD_WAIT: begin
        chan_limit = {8'h00, r[IX_CD_WAIT]}; // [RULE15]
      end
      CH_ANS_DLY: begin
        chan_limit = {8'h00, r[IX_ANS_DLY]}; // [RULE16]
      end
      CH_INTR: begin
        chan_limit = {8'h00, r[IX_SUSP]}; // [RULE2]
      end
      default: begin
        chan_limit = 16'h0000;
      end
    endcase
  endfunction

  // tip-ring reading with the dead band folded to zero
  function automatic logic [7:0] volt_report(input logic [7:0] meas);
    logic signed [7:0] v;
    v = meas;
    if (v < VOLT_FLOOR && v > -VOLT_FLOOR) begin
      volt_report = 8'h00;
    end else begin
      volt_report = meas;
    end
  endfunction

  // one-hot match of a bus address against the register slots
  function automatic logic [NREG-1:0] reg_hit(input logic [7:0] a);
    reg_hit = '0;
    for (int k = 0; k < NREG; k++) begin
      reg_hit[k] = a == REG_OFS[k];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic ib_suspend;
  logic [NCH-1:0] run_eff;
  logic [NCH-1:0] rise;
  logic [15:0] lim;
  logic [NREG-1:0] hit;
  int unit;

  always_comb begin
    nxt_state = state_ff;
    ib_suspend = state_ff.regs[IX_INTR][IB_LSB +: 2] == IB_SUSPEND;
    run_eff = seq_in.run;
    run_eff[CH_INTR] = seq_in.run[CH_INTR] & ib_suspend; // [RULE2]
    lim = 16'h0000;
    hit = reg_hit(bus_req.addr);
    unit = U_FINE;

    // free-running tick generators shared by every channel
    for (int u = 0; u < NUNIT; u++) begin
      if (state_ff.tick_cnt[u] == TICK_LAST[u]) begin
        nxt_state.tick_cnt[u] = '0; // [RULE21]
        nxt_state.tick[u] = 1'b1;
      end else begin
        nxt_state.tick_cnt[u] = state_ff.tick_cnt[u] + TICK_W'(1);
        nxt_state.tick[u] = 1'b0;
      end
    end

    // qualifier and delay channels: count ticks while run holds
    for (int i = 0; i < NCH; i++) begin
      unit = chan_unit(i, state_ff.regs[IX_ANS_SECS] == 8'h00);
      lim = chan_limit(i, state_ff.regs);
      if (!run_eff[i]) begin
        nxt_state.cnt[i] = 16'h0000;
        nxt_state.done[i] = 1'b0;
      end else if (state_ff.cnt[i] >= lim) begin
        nxt_state.done[i] = 1'b1; // [RULE21]
      end else if (state_ff.tick[unit]) begin
        nxt_state.cnt[i] = state_ff.cnt[i] + 16'h0001;
      end
    end
    rise = nxt_state.done & ~state_ff.done;

    nxt_state.out.done = nxt_state.done;

    // off-hook intrusion held off until the suspend time has run
    if (run_eff[CH_INTR] && !nxt_state.done[CH_INTR]) begin
      nxt_state.out.intrusion_blocked = 1'b1; // [RULE2]
    end else begin
      nxt_state.out.intrusion_blocked = 1'b0;
    end

    // loop current sampled once, when the check delay expires
    if (!seq_in.run[CH_OVC]) begin
      nxt_state.out.overcurrent = 1'b0;
    end else if (rise[CH_OVC]) begin
      nxt_state.out.overcurrent = seq_in.loop_sense != 2'h0; // [RULE10]
    end

    // one-cycle events
    if (rise[CH_KISS] && seq_in.security_mode) begin
      nxt_state.out.kissoff_echo = 1'b1; // [RULE13]
    end else begin
      nxt_state.out.kissoff_echo = 1'b0;
    end
    if (rise[CH_CD_WAIT]) begin
      nxt_state.out.call_abort = 1'b1; // [RULE15]
    end else begin
      nxt_state.out.call_abort = 1'b0;
    end

    // ring burst qualification
    nxt_state.ring_prev = seq_in.ring_pulse;
    if (!seq_in.ring_burst) begin
      nxt_state.ring_cnt = 8'h00;
    end else if (seq_in.ring_pulse && !state_ff.ring_prev &&
                 state_ff.ring_cnt != 8'hff) begin
      nxt_state.ring_cnt = state_ff.ring_cnt + 8'h01;
    end
    if (seq_in.ring_burst && nxt_state.ring_cnt >= state_ff.regs[IX_RING_MIN]) begin
      nxt_state.out.ring_qualified = 1'b1; // [RULE17]
    end else begin
      nxt_state.out.ring_qualified = 1'b0;
    end

    // live tip-ring reading
    nxt_state.line_volt = volt_report(seq_in.line_meas); // [RULE18] [RULE22]

    // register writes
    if (bus_req.wr) begin
      for (int k = 0; k < NREG; k++) begin
        if (hit[k]) begin
          nxt_state.regs[k] = bus_req.wdata;
        end
      end
    end

    // register reads: data only in the cycle after the strobe
    nxt_state.rdata = 8'h00;
    if (bus_req.rd) begin
      if (bus_req.addr == OFS_LINE_VOLT) begin
        nxt_state.rdata = state_ff.line_volt; // [RULE18]
      end
      for (int k = 0; k < NREG; k++) begin
        if (hit[k]) begin
          nxt_state.rdata = state_ff.regs[k];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '0;
      for (int k = 0; k < NREG; k++) begin
        state_ff.regs[k] <= REG_RST[k]; // [RULE22]
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign bus_rdata = state_ff.rdata;
  assign seq_out = state_ff.out;

endmodule // mht_timing_regs

`default_nettype wire
